// ==== include/pcf_pkg.sv ====
// Constants shared by the I/O cell bank and its register interface
package pcf_pkg;
   // Register byte offsets
   localparam logic [4:0]  PCF_CTRL_OFS    = 5'h00;
   localparam logic [4:0]  PCF_USED_OFS    = 5'h04;
   localparam logic [4:0]  PCF_IN_REG_OFS  = 5'h08;
   localparam logic [4:0]  PCF_OUT_REG_OFS = 5'h0C;
   localparam logic [4:0]  PCF_OE_REG_OFS  = 5'h10;
   localparam logic [4:0]  PCF_PULLUP_OFS  = 5'h14;
   localparam logic [4:0]  PCF_STATUS_OFS  = 5'h18;
   localparam logic [4:0]  PCF_PAD_IN_OFS  = 5'h1C;
   localparam int unsigned PCF_ADDR_W      = 5;
   // Field positions
   localparam int unsigned PCF_CTRL_FRZ_EN_BIT = 0;
   localparam int unsigned PCF_STAT_USER_BIT   = 0;
   localparam int unsigned PCF_STAT_FRZ_BIT    = 1;
   // Reset values
   localparam logic        PCF_CTRL_FRZ_EN_RST = 1'h0;
   localparam logic [31:0] PCF_MASK_RST        = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0]  PCF_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PCF_RESP_SLVERR = 2'h2;
   // Configuration phase of the bank
   typedef enum logic [1:0] {
      PCF_ST_PRECFG = 2'b01,
      PCF_ST_USER   = 2'b10
   } pcf_cfg_state_t;
endpackage : pcf_pkg

// ==== rtl/pcf_cell.sv ====
// One I/O cell: input capture, freeze hold, output and tri-state registers
`timescale 1ns/10ps
module pcf_cell (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // Bank-level control
   input  wire logic user_mode_in,
   input  wire logic freeze_in,
   input  wire logic in_cap_en_in,
   input  wire logic out_cap_en_in,
   // Cell configuration
   input  wire logic used_in,
   input  wire logic in_reg_sel_in,
   input  wire logic out_reg_sel_in,
   input  wire logic oe_reg_sel_in,
   input  wire logic pullup_sel_in,
   // Core side
   input  wire logic core_dout_in,
   input  wire logic core_oe_in,
   output logic      core_din_out,
   // Pad side
   input  wire logic pad_data_in,
   output logic      pad_data_out,
   output logic      pad_oe_out,
   output logic      pad_pullup_out
);
   logic in_cap_q;
   logic hold_q;
   logic out_q;
   logic oe_q;
   logic din_d;
   logic dout_d;
   logic oe_d;
   logic pullup_d;

   // Input capture register section
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         in_cap_q <= 1'b0;
      end else if (in_cap_en_in) begin
         in_cap_q <= pad_data_in;
      end
   end

   // Freeze hold: tracks the pad until the bank freeze is raised
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_q <= 1'b0;
      end else if (!freeze_in) begin
         hold_q <= pad_data_in;
      end
   end

   // Output register section and tri-state register section
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_q <= 1'b0;
         oe_q  <= 1'b0;
      end else if (out_cap_en_in) begin
         out_q <= core_dout_in;
         oe_q  <= core_oe_in;
      end
   end

   always_comb begin
      din_d    = 1'b0;
      dout_d   = 1'b0;
      oe_d     = 1'b0;
      pullup_d = 1'b1;
      if (user_mode_in) begin
         pullup_d = 1'b0;
         if (used_in) begin
            pullup_d = pullup_sel_in;
            if (in_reg_sel_in) begin
               din_d = in_cap_q;
            end else begin
               din_d = freeze_in ? hold_q : pad_data_in;
            end
            dout_d = out_reg_sel_in ? out_q : core_dout_in;
            oe_d   = oe_reg_sel_in ? oe_q : core_oe_in;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         core_din_out   <= 1'b0;
         pad_data_out   <= 1'b0;
         pad_oe_out     <= 1'b0;
         pad_pullup_out <= 1'b1;
      end else begin
         core_din_out   <= din_d;
         pad_data_out   <= oe_d ? dout_d : 1'b0;
         pad_oe_out     <= oe_d;
         pad_pullup_out <= pullup_d;
      end
   end
endmodule : pcf_cell

// ==== rtl/pcf_bank.sv ====
// Bank of programmable I/O cells with shared freeze and AXI4-Lite control
// Notes on behaviour
// - each cell has input capture, output and tri-state register sections.
// - input registers sample the pad on the ingress enable before the core.
// - per cell, core data goes to the pad registered or directly.
// - optional freeze holds unregistered inputs steady on the core side.
// - one freeze control serves every cell in the bank.
// - registered inputs skip the freeze and hold when their enable stops.
// - while frozen the last value holds; on release the pad is tracked again.
// - before configuration pins are high impedance with weak pull-up.
// - user settings apply only after reset release and configuration done.
// - unused cells get input blocked and pull-up off after configuration.
// - each cell chooses weak pull-up or none on its own.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module pcf_bank #(
   parameter int unsigned NUM_CELLS = 8
) (
   // Clock and reset
   input  wire logic                             sys_clk_in,
   input  wire logic                             resetn_in,
   // AXI4-Lite write
   input  wire logic [pcf_pkg::PCF_ADDR_W-1:0]   s_axi_awaddr_in,
   input  wire logic                             s_axi_awvalid_in,
   output logic                                  s_axi_awready_out,
   input  wire logic [31:0]                      s_axi_wdata_in,
   input  wire logic [3:0]                       s_axi_wstrb_in,
   input  wire logic                             s_axi_wvalid_in,
   output logic                                  s_axi_wready_out,
   output logic [1:0]                            s_axi_bresp_out,
   output logic                                  s_axi_bvalid_out,
   input  wire logic                             s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [pcf_pkg::PCF_ADDR_W-1:0]   s_axi_araddr_in,
   input  wire logic                             s_axi_arvalid_in,
   output logic                                  s_axi_arready_out,
   output logic [31:0]                           s_axi_rdata_out,
   output logic [1:0]                            s_axi_rresp_out,
   output logic                                  s_axi_rvalid_out,
   input  wire logic                             s_axi_rready_in,
   // Device bring-up
   input  wire logic                             por_released_in,
   input  wire logic                             config_done_in,
   // Bank clocking and freeze
   input  wire logic                             freeze_in,
   input  wire logic                             in_clk_en_in,
   input  wire logic                             out_clk_en_in,
   input  wire logic                             clk_en_in,
   // Core side
   input  wire logic [NUM_CELLS-1:0]             core_dout_in,
   input  wire logic [NUM_CELLS-1:0]             core_oe_in,
   output logic      [NUM_CELLS-1:0]             core_din_out,
   // Pad side
   input  wire logic [NUM_CELLS-1:0]             pad_data_in,
   output logic      [NUM_CELLS-1:0]             pad_data_out,
   output logic      [NUM_CELLS-1:0]             pad_oe_out,
   output logic      [NUM_CELLS-1:0]             pad_pullup_out
);
   import pcf_pkg::*;

   pcf_cfg_state_t             cfg_state_q;
   logic                       frz_en_q;
   logic [NUM_CELLS-1:0]       used_q;
   logic [NUM_CELLS-1:0]       in_reg_q;
   logic [NUM_CELLS-1:0]       out_reg_q;
   logic [NUM_CELLS-1:0]       oe_reg_q;
   logic [NUM_CELLS-1:0]       pullup_q;
   logic                       aw_got_q;
   logic                       w_got_q;
   logic [PCF_ADDR_W-1:0]      awaddr_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       user_mode;
   logic                       freeze_act;
   logic                       in_cap_en;
   logic                       out_cap_en;
   logic                       wr_fire;
   logic [31:0]                wr_cur;
   logic [31:0]                wr_new;

   // Merge write data into a register image under byte strobes
   function automatic logic [31:0] pcf_merge(input logic [31:0] cur,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = cur;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction : pcf_merge

   // Widen a cell mask to a bus word
   function automatic logic [31:0] pcf_word(input logic [NUM_CELLS-1:0] m);
      logic [31:0] res;
      res = PCF_MASK_RST;
      res[NUM_CELLS-1:0] = m;
      return res;
   endfunction : pcf_word

   // Decode a byte address to a mapped register
   function automatic logic pcf_mapped(input logic [PCF_ADDR_W-1:0] a);
      logic res;
      res = 1'b0;
      case (a)
         PCF_CTRL_OFS, PCF_USED_OFS, PCF_IN_REG_OFS, PCF_OUT_REG_OFS,
         PCF_OE_REG_OFS, PCF_PULLUP_OFS, PCF_STATUS_OFS, PCF_PAD_IN_OFS: begin
            res = 1'b1;
         end
         default: begin
            res = 1'b0;
         end
      endcase
      return res;
   endfunction : pcf_mapped

   assign user_mode  = (cfg_state_q == PCF_ST_USER);
   assign freeze_act = freeze_in & frz_en_q;
   assign in_cap_en  = in_clk_en_in & clk_en_in;
   assign out_cap_en = out_clk_en_in & clk_en_in;
   assign wr_fire    = aw_got_q & w_got_q & ~s_axi_bvalid_out;
   assign wr_new     = pcf_merge(wr_cur, wdata_q, wstrb_q);

   // Bring-up: pins stay in their pre-configuration state until both events
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_state_q <= PCF_ST_PRECFG;
      end else begin
         case (cfg_state_q)
            PCF_ST_PRECFG: begin
               if (por_released_in && config_done_in) begin
                  cfg_state_q <= PCF_ST_USER;
               end
            end
            PCF_ST_USER: begin
               cfg_state_q <= PCF_ST_USER;
            end
            default: begin
               cfg_state_q <= PCF_ST_PRECFG;
            end
         endcase
      end
   end

   // Write address and data channels, taken in either order
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_got_q          <= 1'b0;
         w_got_q           <= 1'b0;
         awaddr_q          <= '0;
         wdata_q           <= PCF_MASK_RST;
         wstrb_q           <= 4'h0;
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out  <= 1'b1;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got_q          <= 1'b1;
            awaddr_q          <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got_q          <= 1'b1;
            wdata_q          <= s_axi_wdata_in;
            wstrb_q          <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (s_axi_bvalid_out && s_axi_bready_in) begin
            aw_got_q          <= 1'b0;
            w_got_q           <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
         end
      end
   end

   // Write response
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= PCF_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= pcf_mapped(awaddr_q) ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   always_comb begin
      case (awaddr_q)
         PCF_USED_OFS:    wr_cur = pcf_word(used_q);
         PCF_IN_REG_OFS:  wr_cur = pcf_word(in_reg_q);
         PCF_OUT_REG_OFS: wr_cur = pcf_word(out_reg_q);
         PCF_OE_REG_OFS:  wr_cur = pcf_word(oe_reg_q);
         PCF_PULLUP_OFS:  wr_cur = pcf_word(pullup_q);
         default:         wr_cur = PCF_MASK_RST;
      endcase
   end

   // Control and per-cell configuration registers
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frz_en_q  <= PCF_CTRL_FRZ_EN_RST;
         used_q    <= PCF_MASK_RST[NUM_CELLS-1:0];
         in_reg_q  <= PCF_MASK_RST[NUM_CELLS-1:0];
         out_reg_q <= PCF_MASK_RST[NUM_CELLS-1:0];
         oe_reg_q  <= PCF_MASK_RST[NUM_CELLS-1:0];
         pullup_q  <= PCF_MASK_RST[NUM_CELLS-1:0];
      end else if (wr_fire) begin
         case (awaddr_q)
            PCF_CTRL_OFS: begin
               if (wstrb_q[0]) begin
                  frz_en_q <= wdata_q[PCF_CTRL_FRZ_EN_BIT];
               end
            end
            PCF_USED_OFS: begin
               used_q <= wr_new[NUM_CELLS-1:0];
            end
            PCF_IN_REG_OFS: begin
               in_reg_q <= wr_new[NUM_CELLS-1:0];
            end
            PCF_OUT_REG_OFS: begin
               out_reg_q <= wr_new[NUM_CELLS-1:0];
            end
            PCF_OE_REG_OFS: begin
               oe_reg_q <= wr_new[NUM_CELLS-1:0];
            end
            PCF_PULLUP_OFS: begin
               pullup_q <= wr_new[NUM_CELLS-1:0];
            end
            default: begin
               frz_en_q <= frz_en_q;
            end
         endcase
      end
   end

   // Read channel
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= PCF_MASK_RST;
         s_axi_rresp_out   <= PCF_RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b1;
         s_axi_rresp_out   <= pcf_mapped(s_axi_araddr_in) ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
         case (s_axi_araddr_in)
            PCF_CTRL_OFS: begin
               s_axi_rdata_out <= PCF_MASK_RST;
               s_axi_rdata_out[PCF_CTRL_FRZ_EN_BIT] <= frz_en_q;
            end
            PCF_USED_OFS:    s_axi_rdata_out <= pcf_word(used_q);
            PCF_IN_REG_OFS:  s_axi_rdata_out <= pcf_word(in_reg_q);
            PCF_OUT_REG_OFS: s_axi_rdata_out <= pcf_word(out_reg_q);
            PCF_OE_REG_OFS:  s_axi_rdata_out <= pcf_word(oe_reg_q);
            PCF_PULLUP_OFS:  s_axi_rdata_out <= pcf_word(pullup_q);
            PCF_STATUS_OFS: begin
               s_axi_rdata_out <= PCF_MASK_RST;
               s_axi_rdata_out[PCF_STAT_USER_BIT] <= user_mode;
               s_axi_rdata_out[PCF_STAT_FRZ_BIT]  <= freeze_act;
            end
            PCF_PAD_IN_OFS:  s_axi_rdata_out <= pcf_word(pad_data_in);
            default:         s_axi_rdata_out <= PCF_MASK_RST;
         endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out  <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // One cell per pad, all sharing the bank freeze and enables
   for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
      pcf_cell u_cell (
         .sys_clk_in     (sys_clk_in),
         .resetn_in      (resetn_in),
         .user_mode_in   (user_mode),
         .freeze_in      (freeze_act),
         .in_cap_en_in   (in_cap_en),
         .out_cap_en_in  (out_cap_en),
         .used_in        (used_q[g]),
         .in_reg_sel_in  (in_reg_q[g]),
         .out_reg_sel_in (out_reg_q[g]),
         .oe_reg_sel_in  (oe_reg_q[g]),
         .pullup_sel_in  (pullup_q[g]),
         .core_dout_in   (core_dout_in[g]),
         .core_oe_in     (core_oe_in[g]),
         .core_din_out   (core_din_out[g]),
         .pad_data_in    (pad_data_in[g]),
         .pad_data_out   (pad_data_out[g]),
         .pad_oe_out     (pad_oe_out[g]),
         .pad_pullup_out (pad_pullup_out[g])
      );
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_frozen_two;
      freeze_act ##1 (freeze_act && user_mode && $stable(user_mode)
                      && $stable(used_q) && $stable(in_reg_q));
   endsequence

   sequence s_held_capture;
      (user_mode && !in_cap_en) ##1 (user_mode && $stable(used_q) && $stable(in_reg_q));
   endsequence

   sequence s_taken_capture;
      (user_mode && in_cap_en) ##1 (user_mode && $stable(used_q) && $stable(in_reg_q));
   endsequence

   chk_precfg_hiz_pullup: assert property (
      !user_mode |=> (pad_oe_out == '0) && (pad_pullup_out == '1))
      else $error("pins not high impedance with pull-up before configuration");

   chk_user_entry_gate: assert property (
      $rose(user_mode) |-> $past(por_released_in && config_done_in))
      else $error("user mode entered without reset release and configuration");

   chk_unused_blocked: assert property (
      user_mode |=> ((core_din_out | pad_oe_out | pad_pullup_out)
                     & ~$past(used_q)) == '0)
      else $error("unused cell not blocked after configuration");

   chk_pullup_per_cell: assert property (
      user_mode |=> (pad_pullup_out & $past(used_q)) == ($past(pullup_q) & $past(used_q)))
      else $error("pull-up does not follow its own cell setting");

   chk_freeze_holds: assert property (
      s_frozen_two |=> ((core_din_out ^ $past(core_din_out))
                        & $past(used_q & ~in_reg_q)) == '0)
      else $error("unregistered input changed while frozen");

   chk_release_tracks: assert property (
      (user_mode && !freeze_act) |=> ((core_din_out ^ $past(pad_data_in))
                                      & $past(used_q & ~in_reg_q)) == '0)
      else $error("unregistered input does not track pad after release");

   chk_inreg_holds: assert property (
      s_held_capture |=> ((core_din_out ^ $past(core_din_out))
                          & $past(used_q & in_reg_q)) == '0)
      else $error("registered input changed without its enable");

   chk_inreg_samples: assert property (
      s_taken_capture |=> ((core_din_out ^ $past(pad_data_in, 2))
                           & $past(used_q & in_reg_q)) == '0)
      else $error("registered input did not deliver the sampled pad value");

   chk_direct_out_path: assert property (
      user_mode |=> ((pad_oe_out ^ $past(core_oe_in)) & $past(used_q & ~oe_reg_q)) == '0
                 && ((pad_data_out ^ $past(core_dout_in))
                     & $past(used_q & ~out_reg_q & ~oe_reg_q & core_oe_in)) == '0)
      else $error("direct output path does not follow core data");

   chk_hiz_no_data: assert property (
      1'b1 |-> (pad_data_out & ~pad_oe_out) == '0)
      else $error("pad data driven while output disabled");
endmodule : pcf_bank

// ==== dv/pcf_pad_model.sv ====
// Board-side pad model: design drive, board drive, pull-up or floating level
`timescale 1ns/10ps
module pcf_pad_model #(
   parameter int unsigned N = 8
) (
   input  wire logic         clk_in,
   input  wire logic [N-1:0] oe_in,
   input  wire logic [N-1:0] data_in,
   input  wire logic [N-1:0] pullup_in,
   input  wire logic [N-1:0] ext_en_in,
   input  wire logic [N-1:0] ext_val_in,
   output logic      [N-1:0] level_out
);
   logic [N-1:0] last_q;
   always_ff @(posedge clk_in) begin
      last_q <= level_out;
   end
   // A floating pin without pull-up shows a changing level
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (oe_in[i]) level_out[i] = data_in[i];
         else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
         else if (pullup_in[i]) level_out[i] = 1'b1;
         else level_out[i] = ~last_q[i];
      end
   end
endmodule : pcf_pad_model

// ==== dv/pcf_bank_tb_top.sv ====
// Self-checking bench for the I/O cell bank
`timescale 1ns/10ps
module pcf_bank_tb_top;
   import pcf_pkg::*;
   logic        clk, rst_n, awv, wv, bv, br, arv, rv, rr, awr, wrdy, arr;
   logic        por, cfg, frz, in_en, out_en, ce;
   logic [4:0]  awa, ara;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp;
   logic [1:0]  exp_resp = PCF_RESP_OKAY;
   logic [31:0] wd, rdat, r;
   logic [7:0]  dout, oe, din, p_dat, p_oe, p_pu, p_lvl, ext_en, ext_v, eoe, lvl;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'hAE48;
   int          miscompares = 0, compares = 0, cycles = 0;

   pcf_bank #(.NUM_CELLS(8)) uut (.sys_clk_in(clk), .resetn_in(rst_n),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rr), .por_released_in(por), .config_done_in(cfg), .freeze_in(frz),
      .in_clk_en_in(in_en), .out_clk_en_in(out_en), .clk_en_in(ce), .core_dout_in(dout),
      .core_oe_in(oe), .core_din_out(din), .pad_data_in(p_lvl), .pad_data_out(p_dat),
      .pad_oe_out(p_oe), .pad_pullup_out(p_pu));
   pcf_pad_model #(.N(8)) pads (.clk_in(clk), .oe_in(p_oe), .data_in(p_dat),
      .pullup_in(p_pu), .ext_en_in(ext_en), .ext_val_in(ext_v), .level_out(p_lvl));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      check("bresp", bresp, exp_resp);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clk);
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      exp_q.push_back(exp);
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rr <= 1'b0;
      check("rresp", rresp, exp_resp);
   endtask : rd

   always @(posedge clk) if (rv && rr) check("rdata", rdat, exp_q.pop_front());
   always @(posedge clk) begin
      cycles++;
      if (cycles > 4000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      rst_n = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0; ws = 0;
      por = 0; cfg = 0; frz = 0; in_en = 0; out_en = 0; ce = 0; dout = 0; oe = 0;
      ext_en = 0; ext_v = 0;
      step(12);
      rst_n <= 1'b1;
      step(2);
      check("pad_oe", p_oe, 0);
      check("pullup", p_pu, 8'hFF);
      rd(PCF_PAD_IN_OFS, 32'hFF);
      wr(PCF_USED_OFS, 32'h0F);
      wr(PCF_PULLUP_OFS, 32'h05);
      wr(PCF_IN_REG_OFS, 32'h04);
      wr(PCF_OUT_REG_OFS, 32'h02);
      wr(PCF_OE_REG_OFS, 32'h02);
      wr(PCF_CTRL_OFS, 32'h01);
      wr(PCF_STATUS_OFS, 32'h03);
      rd(PCF_PULLUP_OFS, 32'h05);
      oe <= 8'h01; dout <= 8'h01; por <= 1'b1; ext_en <= 8'hFF;
      step(4);
      check("pad_oe", p_oe, 0);
      check("pullup", p_pu, 8'hFF);
      rd(PCF_STATUS_OFS, 32'h0);
      cfg <= 1'b1;
      step(4);
      check("pullup", p_pu, 8'h05);
      rd(PCF_STATUS_OFS, 32'h1);
      repeat (8) begin
         r = xs();
         dout <= r[7:0]; oe <= r[15:8]; ext_v <= r[23:16];
         eoe = r[15:8] & 8'h0D;
         lvl = (eoe & r[7:0]) | (~eoe & r[23:16]);
         step(2);
         check("pad_oe", p_oe, eoe);
         check("pad_data", p_dat, r[7:0] & eoe);
         step(1);
         check("core_din", din, lvl & 8'h0B);
      end
      oe <= 8'h02; dout <= 8'h02; ext_v <= 8'h04; in_en <= 1'b1; out_en <= 1'b1; ce <= 1'b0;
      step(4);
      check("pad_oe", p_oe, 0);
      check("core_din", din & 8'h04, 0);
      ce <= 1'b1;
      step(1);
      in_en <= 1'b0; out_en <= 1'b0;
      step(3);
      check("pad_oe", p_oe, 8'h02);
      check("pad_data", p_dat, 8'h02);
      check("core_din", din & 8'h04, 8'h04);
      oe <= 8'h00; ext_v <= 8'h09;
      step(4);
      check("core_din", din, 8'h0F);
      frz <= 1'b1;
      step(2);
      ext_v <= 8'h00;
      step(4);
      check("core_din", din & 8'h0B, 8'h0B);
      rd(PCF_STATUS_OFS, 32'h3);
      frz <= 1'b0;
      step(4);
      check("core_din", din & 8'h0B, 8'h02);
      exp_resp = PCF_RESP_SLVERR;
      wr(5'h02, 32'hFF);
      rd(5'h02, 32'h0);
      exp_resp = PCF_RESP_OKAY;
      rd(PCF_USED_OFS, 32'h0F);
      finish_test();
   end
endmodule : pcf_bank_tb_top
